// [bench/timer16_capture_overflow_rules_tb.sv]
// self-checking bench of the capture timer through its register port
// assumes trig_model drives the pins and the checker is bound in
`timescale 1ns/1ns
module timer16_capture_overflow_rules_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, trigger_input_a, trigger_input_b, pulse_out, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_seen, old_v;  // last read, earlier capture
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_seen;       // answer code of last access
  int          n_mismatch, cmp_count, n;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_type;
  // write then read back: stopped edge setup, mask, read-only count, unmapped, flag, w1c
  row_type rows [6] = '{'{timer16_pkg::OFF_CTRL, 32'h0000_01D4, 32'h0000_01D4, 2'b00},
    '{timer16_pkg::OFF_IMSK, 32'h0000_0007, 32'h0000_0007, 2'b00},
    '{timer16_pkg::OFF_COUNT, 32'h0000_1234, 32'h0000_0000, 2'b00},
    '{8'h1C, 32'h0000_FFFF, 32'h0000_0000, 2'b10},
    '{timer16_pkg::OFF_FLAG, 32'h0000_0000, 32'h0000_0000, 2'b00},
    '{timer16_pkg::OFF_IST, 32'h0000_0007, 32'h0000_0000, 2'b00}};
  timer16_top i_timer16_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .trigger_input_a(trigger_input_a),
    .trigger_input_b(trigger_input_b), .pulse_out(pulse_out), .irq(irq));
  trig_model i_trig_model (.aclk(aclk), .pulse_out(pulse_out),
    .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b));
  always #20 aclk = ~aclk;  // 25 MHz
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // offer address and data together, drop each once taken, then take the answer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    {rd_seen, resp_seen} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(what, exp, rd_seen);
  endtask : rd_chk
  // bounded wait for the interrupt level
  task automatic wait_irq(input int lim);
    for (n = 0; irq !== 1'b1 && n < lim; n++) @(posedge aclk);
  endtask : wait_irq
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    {s_axi_wdata, s_axi_wstrb} = 36'h0_0000_000F;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].d);
      check("write resp", {30'h0, rows[i].r}, {30'h0, resp_seen});
      rd_chk("read data", rows[i].a, rows[i].q);
      check("read resp", {30'h0, rows[i].r}, {30'h0, resp_seen});
    end
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_01D5);  // start with capture on, free run
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_01D9);  // edge change refused while running
    rd_chk("ctrl edge kept", timer16_pkg::OFF_CTRL, 32'h0000_01D5);
    i_trig_model.drive(1'b1, 1'b1, 4);  // valid edge on pin b
    wait_irq(20);
    rd_chk("ist cap a", timer16_pkg::OFF_IST, 32'h0000_0001);
    axi_read(timer16_pkg::OFF_CCA);
    old_v = rd_seen;
    axi_write(timer16_pkg::OFF_IST, 32'h0000_0007);
    i_trig_model.drive(1'b0, 1'b1, 4);  // valid edge on pin a
    wait_irq(20);
    rd_chk("ist cap b", timer16_pkg::OFF_IST, 32'h0000_0002);
    axi_write(timer16_pkg::OFF_IST, 32'h0000_0007);
    i_trig_model.drive(1'b0, 1'b0, 8);  // reverse edge on pin a captures silently
    rd_chk("ist reverse", timer16_pkg::OFF_IST, 32'h0000_0000);
    axi_read(timer16_pkg::OFF_CCA);
    check("cca reverse", 32'h0000_0001, {31'h0, rd_seen != old_v});
    axi_read(timer16_pkg::OFF_CCB);
    old_v = rd_seen;
    // a read of the capture register lands on top of a valid edge
    fork
      i_trig_model.drive(1'b0, 1'b1, 4);
      begin
        repeat (2) @(posedge aclk);
        axi_read(timer16_pkg::OFF_CCB);
      end
    join
    wait_irq(20);
    rd_chk("ist coincide", timer16_pkg::OFF_IST, 32'h0000_0002);
    axi_read(timer16_pkg::OFF_CCB);
    check("ccb coincide", 32'h0000_0001, {31'h0, rd_seen != old_v});
    i_trig_model.drive(1'b0, 1'b0, 4);
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_0204);  // stopped, one-shot, rise on a
    axi_write(timer16_pkg::OFF_CCB, 32'h0000_000A);
    axi_write(timer16_pkg::OFF_CCA, 32'h0000_0014);
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_0207);  // clear and start on trigger a
    i_trig_model.drive(1'b0, 1'b1, 4);
    for (n = 0; pulse_out !== 1'b1 && n < 60; n++) @(posedge aclk);
    for (n = 0; pulse_out === 1'b1 && n < 60; n++) @(posedge aclk);
    check("pulse width", 32'h0000_000A, n);
    rd_chk("ist match", timer16_pkg::OFF_IST, 32'h0000_0003);
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_0000);
    axi_write(timer16_pkg::OFF_IMSK, 32'h0000_0004);
    axi_write(timer16_pkg::OFF_IST, 32'h0000_0007);
    axi_write(timer16_pkg::OFF_CCA, 32'h0000_FFFF);
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_0002);  // clear on match at the top value
    wait_irq(70000);
    rd_chk("flag wrap", timer16_pkg::OFF_FLAG, 32'h0000_0001);
    axi_read(timer16_pkg::OFF_IST);
    check("ist ovf", 32'h0000_0001, {31'h0, rd_seen[2]});
    repeat (100) @(posedge aclk);
    rd_chk("flag held", timer16_pkg::OFF_FLAG, 32'h0000_0001);
    axi_write(timer16_pkg::OFF_FLAG, 32'h0000_0000);
    rd_chk("flag cleared", timer16_pkg::OFF_FLAG, 32'h0000_0000);
    axi_write(timer16_pkg::OFF_IST, 32'h0000_0007);
    repeat (4) @(posedge aclk);
    check("irq cleared", 32'h0000_0000, {31'h0, irq});
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("ctrl after reset", timer16_pkg::OFF_CTRL, 32'h0000_0000);
    axi_write(timer16_pkg::OFF_CTRL, 32'h0000_00CD);  // both edges on a, fall on b, free run
    i_trig_model.drive(1'b0, 1'b0, 4);  // falling edge on pin a counts as valid
    i_trig_model.drive(1'b1, 1'b0, 4);  // falling edge on pin b
    rd_chk("ist both fall", timer16_pkg::OFF_IST, 32'h0000_0003);
    stop_test();
  end
  // the overflow wait dominates the run; allow ample margin over it
  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    stop_test();
  end
endmodule : timer16_capture_overflow_rules_tb

// [bench/timer16_props.sv]
// concurrent checks on the timer's bus handshakes, interrupt and reset levels
// assumes it is bound into timer16_top and that there is one aclk domain
`timescale 1ns/1ns
module timer16_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              pulse_out,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] wr_age_q;  // edges since write data was taken, saturating
  // irq may only fall shortly after software wrote something
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_age_q <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wr_age_q <= 3'h0;
    else if (wr_age_q != 3'h7) wr_age_q <= wr_age_q + 3'h1;
  end
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("bad unmapped read");
  irq_sticky_a: assert property ($fell(irq) |-> wr_age_q < 3'h4)
    else $error("irq fell with no write");
  reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
    |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !pulse_out) else $error("busy in reset");
endmodule : timer16_props

bind timer16_top timer16_props #(.ADDR_W(ADDR_W)) i_timer16_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pulse_out(pulse_out), .irq(irq)
);

// [bench/trig_model.sv]
// stand-in for the two external trigger pins of the timer
// assumes pins idle low and every level is held longer than two clocks
`timescale 1ns/1ns
module trig_model (
  input  wire logic aclk,
  input  wire logic pulse_out,
  output logic      trigger_input_a,
  output logic      trigger_input_b
);
  initial begin
    trigger_input_a = 1'b0;
    trigger_input_b = 1'b0;
  end
  // set one pin after an edge and keep it, so the synchroniser sees it
  task automatic drive(input logic sel_b, input logic lvl, input int hold);
    if (!sel_b) wait (pulse_out !== 1'b1);
    @(posedge aclk);
    if (sel_b) trigger_input_b <= lvl;
    else trigger_input_a <= lvl;
    repeat (hold) @(posedge aclk);
  endtask : drive
endmodule : trig_model

// [hdl/edge_detect.sv]
// synchronises one trigger pin and reports its valid and reverse edges
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ns
module edge_detect (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  trig_if.det       trig
);
  logic sync1_q;  // first stage, read only by sync2_q
  logic sync2_q;  // settled pin level
  logic prev_q;   // level one cycle earlier
  wire  rise = sync2_q & ~prev_q;
  wire  fall = ~sync2_q & prev_q;

  // prev starts low, so a pin already high after reset reads as a rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // both-edges selection leaves no reverse phase
  assign trig.valid_edge   = (trig.edge_sel == timer16_pkg::ES_RISE) ? rise :
                             (trig.edge_sel == timer16_pkg::ES_FALL) ? fall :
                             (trig.edge_sel == timer16_pkg::ES_BOTH) ? (rise | fall) : 1'b0;
  assign trig.reverse_edge = (trig.edge_sel == timer16_pkg::ES_RISE) ? fall :
                             (trig.edge_sel == timer16_pkg::ES_FALL) ? rise : 1'b0;
endmodule : edge_detect

// [hdl/timer16_pkg.sv]
// constants, register map and state types of the 16-bit capture timer
// assumes a single aclk domain and an axi4-lite register port
// Notes on behaviour
// - capture still happens during coinciding register read
// - irq on valid edge, none on reverse
// - capture registers undefined once timer stops
// - overflow flag on wrap, incl. match FFFF
// - early clear before 0001 is undone
package timer16_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CCA   = 8'h08;
  localparam logic [7:0] OFF_CCB   = 8'h0C;
  localparam logic [7:0] OFF_FLAG  = 8'h10;
  localparam logic [7:0] OFF_IST   = 8'h14;
  localparam logic [7:0] OFF_IMSK  = 8'h18;
  // control field positions
  localparam int CTRL_MODE  = 0;  // op_mode_bit_lo, op_mode_bit_hi at +1
  localparam int CTRL_ES_A  = 2;  // edge_select_bit0/bit1 of trigger a
  localparam int CTRL_ES_B  = 4;  // edge select of trigger b
  localparam int CTRL_CAP_A = 6;  // capcmp_reg_a works as capture
  localparam int CTRL_CAP_B = 7;  // capcmp_reg_b works as capture
  localparam int CTRL_REV_A = 8;  // reg a also captures on reverse edge of a
  localparam int CTRL_OSP   = 9;  // one-shot pulse enable
  localparam int CTRL_W     = 10;
  // interrupt status bits
  localparam int IRQ_A   = 0;
  localparam int IRQ_B   = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_W   = 3;
  // counter landmarks and reset values
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // edge selection codes
  localparam logic [1:0] ES_FALL = 2'b00;
  localparam logic [1:0] ES_RISE = 2'b01;
  localparam logic [1:0] ES_BOTH = 2'b11;
  // operating modes, gray along stop, free, trigger-clear, match-clear
  typedef enum logic [1:0] {
    MODE_STOP      = 2'b00,
    MODE_FREE      = 2'b01,
    MODE_CLR_TRIG  = 2'b11,
    MODE_CLR_MATCH = 2'b10
  } op_mode_type;
  // one-shot pulse states
  typedef enum logic [1:0] {
    OS_IDLE   = 2'b00,
    OS_DELAY  = 2'b01,
    OS_ACTIVE = 2'b11
  } one_shot_type;
endpackage : timer16_pkg

// [hdl/timer16_top.sv]
// 16-bit timer with two capture/compare registers, overflow flag,
// one-shot pulse and an axi4-lite register port
// assumes trigger pins are asynchronous; one clock, synchronous reset
`timescale 1ns/1ns
module timer16_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              trigger_input_a,
  input  wire logic              trigger_input_b,
  output logic                   pulse_out,
  output logic                   irq
);
  // merge a write word into an old value under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : strb_merge

  // trigger edge detection
  trig_if ta ();
  trig_if tb ();
  edge_detect u_det_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (trigger_input_a),
    .trig    (ta)
  );
  edge_detect u_det_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (trigger_input_b),
    .trig    (tb)
  );

  // registers
  logic [timer16_pkg::CTRL_W-1:0] ctrl_q;      // mode, edges, capture setup
  logic [15:0]                    up_counter;  // running count
  logic [15:0]                    capcmp_reg_a;
  logic [15:0]                    capcmp_reg_b;
  logic                           overflow_flag;
  logic                           ovf_win_q;   // counter still at 0000 after wrap
  logic [timer16_pkg::IRQ_W-1:0]  ist_q;       // sticky interrupt status
  logic [timer16_pkg::IRQ_W-1:0]  imsk_q;      // interrupt enables
  timer16_pkg::one_shot_type      os_q;
  // axi state
  logic              aw_full_q;
  logic              w_full_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;

  // control fields
  timer16_pkg::op_mode_type mode;
  assign mode = timer16_pkg::op_mode_type'(ctrl_q[timer16_pkg::CTRL_MODE +: 2]);
  wire running = (mode != timer16_pkg::MODE_STOP);
  wire cap_a   = ctrl_q[timer16_pkg::CTRL_CAP_A];
  wire cap_b   = ctrl_q[timer16_pkg::CTRL_CAP_B];
  wire rev_a   = ctrl_q[timer16_pkg::CTRL_REV_A];
  wire osp_en  = ctrl_q[timer16_pkg::CTRL_OSP];
  assign ta.edge_sel = ctrl_q[timer16_pkg::CTRL_ES_A +: 2];
  assign tb.edge_sel = ctrl_q[timer16_pkg::CTRL_ES_B +: 2];

  // write channel bookkeeping
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire [7:0] wa = 8'(waddr_q);
  wire wr_ctrl = do_wr && (wa == timer16_pkg::OFF_CTRL);
  wire wr_cca  = do_wr && (wa == timer16_pkg::OFF_CCA);
  wire wr_ccb  = do_wr && (wa == timer16_pkg::OFF_CCB);
  wire wr_flag = do_wr && (wa == timer16_pkg::OFF_FLAG);
  wire wr_ist  = do_wr && (wa == timer16_pkg::OFF_IST);
  wire wr_imsk = do_wr && (wa == timer16_pkg::OFF_IMSK);
  wire wr_ro   = do_wr && (wa == timer16_pkg::OFF_COUNT);
  wire wr_ok   = wr_ctrl | wr_cca | wr_ccb | wr_flag | wr_ist | wr_imsk | wr_ro;
  localparam logic [31:0] WORD_ZERO_W = timer16_pkg::WORD_ZERO;
  wire [31:0] wmerge = strb_merge(WORD_ZERO_W, wdata_q, wstrb_q);

  // counter events
  wire match_a     = (up_counter == capcmp_reg_a);
  wire match_b     = (up_counter == capcmp_reg_b);
  wire clr_trig    = (mode == timer16_pkg::MODE_CLR_TRIG) && ta.valid_edge;
  wire clr_match   = (mode == timer16_pkg::MODE_CLR_MATCH) && match_a;
  // a wrap from FFFF covers both plain overflow and a match-clear at FFFF
  wire ovf_evt     = running && (up_counter == timer16_pkg::CNT_MAX)
                     && !clr_trig;
  // capture events: reg a from trigger b valid edge or trigger a reverse edge
  wire cap_a_valid = running && cap_a && tb.valid_edge;
  wire cap_a_rev   = running && cap_a && rev_a && ta.reverse_edge;
  wire cap_a_evt   = cap_a_valid | cap_a_rev;
  wire cap_b_evt   = running && cap_b && ta.valid_edge;
  // capture interrupts come from valid edges only, never the reverse phase
  wire irq_a_evt   = cap_a ? cap_a_valid : (running && match_a);
  wire irq_b_evt   = cap_b ? cap_b_evt : (running && match_b);

  // counter: cleared when stopped or on a clear condition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_counter <= timer16_pkg::CNT_ZERO;
    end else if (!running || clr_trig || clr_match) begin
      up_counter <= timer16_pkg::CNT_ZERO;
    end else begin
      up_counter <= up_counter + timer16_pkg::CNT_ONE;
    end
  end

  // control register; edge selection of trigger a frozen unless the timer is stopped
  logic [timer16_pkg::CTRL_W-1:0] ctrl_d;
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wmerge[timer16_pkg::CTRL_W-1:0];
      if (running) begin
        ctrl_d[timer16_pkg::CTRL_ES_A +: 2] = ctrl_q[timer16_pkg::CTRL_ES_A +: 2];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl_q <= '0;
    else          ctrl_q <= ctrl_d;
  end

  // capture/compare a; capture beats a bus write in the same cycle,
  // a capture register does not keep its value across a stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capcmp_reg_a <= timer16_pkg::CNT_ZERO;
    end else if (cap_a_evt) begin
      capcmp_reg_a <= up_counter;
    end else if (cap_a && !running) begin
      capcmp_reg_a <= timer16_pkg::CNT_ZERO;
    end else if (wr_cca) begin
      capcmp_reg_a <= wmerge[15:0];
    end
  end

  // capture/compare b, same priorities
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capcmp_reg_b <= timer16_pkg::CNT_ZERO;
    end else if (cap_b_evt) begin
      capcmp_reg_b <= up_counter;
    end else if (cap_b && !running) begin
      capcmp_reg_b <= timer16_pkg::CNT_ZERO;
    end else if (wr_ccb) begin
      capcmp_reg_b <= wmerge[15:0];
    end
  end

  // overflow window: open from the wrap until the count leaves 0000
  wire flag_clear = wr_flag && wstrb_q[0] && !wdata_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_win_q     <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      ovf_win_q     <= ovf_evt;
      // set wins over clear; a clear inside the window is undone
      overflow_flag <= ovf_evt | ovf_win_q
                       | (overflow_flag & !flag_clear);
    end
  end

  // one-shot: trigger a valid edge starts it, match b raises, match a ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_q      <= timer16_pkg::OS_IDLE;
      pulse_out <= 1'b0;
    end else if (!osp_en || !running) begin
      os_q      <= timer16_pkg::OS_IDLE;
      pulse_out <= 1'b0;
    end else begin
      case (os_q)
        timer16_pkg::OS_IDLE: begin
          if (ta.valid_edge) os_q <= timer16_pkg::OS_DELAY;
        end
        timer16_pkg::OS_DELAY: begin
          if (match_b) begin
            os_q      <= timer16_pkg::OS_ACTIVE;
            pulse_out <= 1'b1;
          end
        end
        timer16_pkg::OS_ACTIVE: begin
          // a trigger here is ignored; the level runs to its end
          if (match_a) begin
            os_q      <= timer16_pkg::OS_IDLE;
            pulse_out <= 1'b0;
          end
        end
        default: os_q <= timer16_pkg::OS_IDLE;
      endcase
    end
  end

  // sticky interrupt status, write one to clear, set wins
  wire [timer16_pkg::IRQ_W-1:0] ev  = {ovf_evt, irq_b_evt, irq_a_evt};
  wire [timer16_pkg::IRQ_W-1:0] w1c = wr_ist ? wmerge[timer16_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q  <= '0;
      imsk_q <= '0;
      irq    <= 1'b0;
    end else begin
      ist_q  <= ev | (ist_q & ~w1c);
      if (wr_imsk) imsk_q <= wmerge[timer16_pkg::IRQ_W-1:0];
      irq    <= |(ist_q & imsk_q);
    end
  end

  // axi write: address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      waddr_q       <= '0;
      wdata_q       <= timer16_pkg::WORD_ZERO;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= timer16_pkg::RESP_OKAY;
    end else begin
      if (aw_take) waddr_q <= s_axi_awaddr;
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_full_q     <= do_wr ? 1'b0 : (aw_full_q | aw_take);
      w_full_q      <= do_wr ? 1'b0 : (w_full_q | w_take);
      s_axi_awready <= do_wr | ~(aw_full_q | aw_take);
      s_axi_wready  <= do_wr | ~(w_full_q | w_take);
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read decode; a read beside a capture shows the older value
  wire [7:0] ra   = 8'(s_axi_araddr);
  wire ar_take    = s_axi_arvalid & s_axi_arready;
  wire [31:0] rd_word =
    (ra == timer16_pkg::OFF_CTRL)  ? 32'(ctrl_q) :
    (ra == timer16_pkg::OFF_COUNT) ? 32'(up_counter) :
    (ra == timer16_pkg::OFF_CCA)   ? 32'(capcmp_reg_a) :
    (ra == timer16_pkg::OFF_CCB)   ? 32'(capcmp_reg_b) :
    (ra == timer16_pkg::OFF_FLAG)  ? 32'(overflow_flag) :
    (ra == timer16_pkg::OFF_IST)   ? 32'(ist_q) :
    (ra == timer16_pkg::OFF_IMSK)  ? 32'(imsk_q) : timer16_pkg::WORD_ZERO;
  wire rd_ok = (ra == timer16_pkg::OFF_CTRL) || (ra == timer16_pkg::OFF_COUNT)
            || (ra == timer16_pkg::OFF_CCA) || (ra == timer16_pkg::OFF_CCB)
            || (ra == timer16_pkg::OFF_FLAG) || (ra == timer16_pkg::OFF_IST)
            || (ra == timer16_pkg::OFF_IMSK);
  wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // axi read: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= timer16_pkg::WORD_ZERO;
      s_axi_rresp   <= timer16_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= ~rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
      end
    end
  end
endmodule : timer16_top

// [hdl/trig_if.sv]
// carrier between the edge detector and the timer core
// assumes both ends sit on aclk
`timescale 1ns/1ns
interface trig_if;
  logic [1:0] edge_sel;      // selected valid edge
  logic       valid_edge;    // one-cycle pulse on the valid edge
  logic       reverse_edge;  // one-cycle pulse on the opposite edge
  modport det (input edge_sel, output valid_edge, output reverse_edge);
  modport use_side (output edge_sel, input valid_edge, input reverse_edge);
endinterface : trig_if
